// ### tr_pkg.sv
// package for the table-read and nibble-swap execution block
// assumes a single pclk domain and an APB master with 32-bit data
package tr_pkg;

    // **********************************************************
    // register map (byte addresses) and reset values
    // **********************************************************
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_INSTR   = 8'h04;
    localparam logic [7:0]  ADDR_PTR     = 8'h08;
    localparam logic [7:0]  ADDR_LATCH   = 8'h0c;
    localparam logic [7:0]  ADDR_WREG    = 8'h10;
    localparam logic [7:0]  ADDR_BANK    = 8'h14;
    localparam logic [7:0]  ADDR_STATUS  = 8'h18;
    localparam logic [7:0]  ADDR_FLAGS   = 8'h1c;
    localparam logic [7:0]  ADDR_INDEX   = 8'h20;
    localparam logic [7:0]  ADDR_DADDR   = 8'h24;
    localparam logic [7:0]  ADDR_DDATA   = 8'h28;

    localparam logic [20:0] RST_PTR      = 21'h000000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  RST_BANK     = 4'h0;
    localparam logic [4:0]  RST_FLAGS    = 5'h00;
    localparam logic [11:0] RST_INDEX    = 12'h000;
    localparam logic [15:0] RST_INSTR    = 16'h0000;

    // field positions
    localparam int CTRL_EXT_BIT  = 0;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_REFUSE_BIT = 1;
    localparam int ST_UNKN_BIT   = 2;

    // **********************************************************
    // opcode layout and operand addressing constants
    // **********************************************************
    localparam logic [13:0] TABLE_READ_PATTERN = 14'h0002; // 0000 0000 0000 10nn
    localparam logic [5:0]  SWAP_PATTERN       = 6'h0e;    // 0011 10da
    localparam logic [7:0]  ACCESS_LIMIT       = 8'h5f;    // 95
    localparam logic [3:0]  ACCESS_HIGH        = 4'hf;     // upper access bank page

    typedef enum logic [1:0] {
        PTR_KEEP     = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC  = 2'b11
    } tr_ptr_mode_t;

    typedef struct packed {
        logic         is_table_read;
        logic         is_swap;
        tr_ptr_mode_t mode;
        logic         dest_f;
        logic         acc_banked;
        logic [7:0]   fopnd;
    } tr_decode_t;

    typedef struct packed {
        logic        rd;
        logic [19:0] word_addr;
    } tr_pm_req_t;

    // split one opcode word into its fields
    function automatic tr_decode_t tr_decode(input logic [15:0] op);
        tr_decode_t d;
        d.is_table_read = (op[15:2] == TABLE_READ_PATTERN);
        d.is_swap       = (op[15:10] == SWAP_PATTERN);
        d.mode          = tr_ptr_mode_t'(op[1:0]);
        d.dest_f        = op[9];
        d.acc_banked    = op[8];
        d.fopnd    = op[7:0];
        return d;
    endfunction : tr_decode

endpackage : tr_pkg

// ### tr_tbl_ptr.sv
// pointer arithmetic and byte selection for the table read
// assumes the caller registers the results; purely combinational
`timescale 1ns/1ps
module tr_tbl_ptr
    import tr_pkg::*;
(
    // current pointer and update mode
    input  wire logic [20:0] ptr,
    input  wire logic [1:0]  mode,
    // program word returned by memory
    input  wire logic [15:0] pm_word,
    // access address, pointer after the instruction, selected byte
    output logic [20:0]      access_addr,
    output logic [20:0]      next_ptr,
    output logic [7:0]       sel_byte
);

    // ****************************************************
    // pointer update
    // ****************************************************
    wire logic [20:0] ptr_inc = ptr + 21'h000001; // wraps inside 2 Mbyte
    wire logic [20:0] ptr_dec = ptr - 21'h000001;

    // pre-increment moves the pointer before the access
    assign access_addr = (mode == PTR_PRE_INC) ? ptr_inc : ptr;
    assign next_ptr    = (mode == PTR_KEEP)     ? ptr     :
                         (mode == PTR_POST_DEC) ? ptr_dec : ptr_inc;

    // bit 0 picks low or high byte of the word
    assign sel_byte = access_addr[0] ? pm_word[15:8] : pm_word[7:0];

endmodule : tr_tbl_ptr

// ### tr_opnd.sv
// operand address resolution and nibble swap for the register operand
// assumes a 12-bit data space; purely combinational
`timescale 1ns/1ps
module tr_opnd
    import tr_pkg::*;
(
    // instruction operand fields
    input  wire logic [7:0]  fopnd,
    input  wire logic        acc_banked,
    // addressing context
    input  wire logic [3:0]  bank_sel,
    input  wire logic        ext_en,
    input  wire logic [11:0] index_base,
    // source byte read from data memory
    input  wire logic [7:0]  src,
    // resolved address and swapped value
    output logic [11:0]      daddr,
    output logic [7:0]       swapped
);

    // ****************************************************
    // address resolution
    // ****************************************************
    wire logic low_half = (fopnd <= ACCESS_LIMIT);
    wire logic indexed  = !acc_banked && ext_en && low_half;
    wire logic [11:0] access_addr = low_half ? {4'h0, fopnd}
                                             : {ACCESS_HIGH, fopnd};
    wire logic [11:0] banked_addr = {bank_sel, fopnd};
    wire logic [11:0] index_addr  = index_base + {4'h0, fopnd};

    // indexed mode overrides the plain access bank
    assign daddr = indexed ? index_addr : (acc_banked ? banked_addr : access_addr);

    // low nibble goes high, high nibble goes low
    assign swapped = {src[3:0], src[7:4]};

endmodule : tr_opnd

// ### tr_core.sv
// top of the table-read and nibble-swap execution block
// assumes an APB master on pclk and a program memory word port that
// answers a held read request with a one-cycle acknowledge
//
// Behaviour
// - the table read is the 16-bit word 0000 0000 0000 10nn with nn the pointer mode.
// - mode 0 keeps the pointer, 1 post-increments, 2 post-decrements, 3 pre-increments.
// - the addressed program byte goes to the latch, using the pointer after pre-increment.
// - the table pointer is a 21-bit byte address.
// - the pointer covers a two megabyte program space.
// - pointer bit 0 clear returns the low byte of the program word.
// - pointer bit 0 set returns the high byte of the program word.
// - the swap instruction 0011 10da f exchanges the two nibbles of the source byte.
// - destination bit 0 sends the result to the working register only.
// - destination bit 1 writes the result back to the source register.
// - access bit 0 resolves the operand in the access bank.
// - access bit 1 uses the bank select register to pick the bank.
// - access bit 0 with extended set and operand up to 95 uses indexed literal offset.
`timescale 1ns/1ps
module tr_core
    import tr_pkg::*;
#(
    parameter int DMEM_DEPTH = 4096
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // program memory read port
    output logic             pm_rd,
    output logic [19:0]      pm_word_addr,
    input  wire logic [15:0] pm_rdata,
    input  wire logic        pm_ack,
    // execution state
    output logic             busy
);

    // ****************************************************
    // state and registers
    // ****************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_PMRD = 2'b10
    } tr_state_t;

    tr_state_t   state_ff;
    logic        ext_en_ff;
    logic [15:0] instr_ff;
    logic [20:0] table_byte_pointer_ff;
    logic [7:0]  table_latch_reg_ff;
    logic [7:0]  wreg_ff;
    logic [3:0]  bank_select_reg_ff;
    logic [4:0]  flags_ff;
    logic [11:0] index_ff;
    logic [11:0] dbg_addr_ff;
    logic        refused_ff;
    logic        unknown_ff;
    tr_pm_req_t  pm_req_ff;
    logic [7:0]  dmem [DMEM_DEPTH];

    // ****************************************************
    // apb decode
    // ****************************************************
    wire logic        wr_acc  = psel && penable && pwrite;
    wire logic        rd_acc  = psel && penable && !pwrite;
    wire logic [7:0]  reg_off = paddr[7:0];
    wire logic        mapped  = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00)
                                && (reg_off <= ADDR_DDATA);
    wire logic        idle    = (state_ff == ST_IDLE);
    wire logic        wr_ctrl   = wr_acc && mapped && (reg_off == ADDR_CTRL);
    wire logic        wr_instr  = wr_acc && mapped && (reg_off == ADDR_INSTR);
    wire logic        wr_ptr    = wr_acc && mapped && (reg_off == ADDR_PTR);
    wire logic        wr_wreg   = wr_acc && mapped && (reg_off == ADDR_WREG);
    wire logic        wr_bank   = wr_acc && mapped && (reg_off == ADDR_BANK);
    wire logic        wr_status = wr_acc && mapped && (reg_off == ADDR_STATUS);
    wire logic        wr_flags  = wr_acc && mapped && (reg_off == ADDR_FLAGS);
    wire logic        wr_index  = wr_acc && mapped && (reg_off == ADDR_INDEX);
    wire logic        wr_daddr  = wr_acc && mapped && (reg_off == ADDR_DADDR);
    wire logic        wr_ddata  = wr_acc && mapped && (reg_off == ADDR_DDATA);

    // software may not disturb operand state while an instruction runs
    wire logic sw_conflict = !idle && (wr_instr || wr_ptr || wr_wreg || wr_bank
                                       || wr_index || wr_ddata);
    wire logic launch      = wr_instr && idle;

    // ****************************************************
    // instruction decode and datapath
    // ****************************************************
    wire tr_decode_t dec     = tr_decode(instr_ff);
    wire tr_decode_t new_dec = tr_decode(pwdata[15:0]);
    wire logic       new_bad = !new_dec.is_table_read && !new_dec.is_swap;

    logic [20:0] ptr_access;
    logic [20:0] ptr_next;
    logic [7:0]  pm_byte;
    logic [11:0] opnd_addr;
    logic [7:0]  swap_val;

    tr_tbl_ptr u_ptr (
        .ptr         (table_byte_pointer_ff),
        .mode        (dec.mode),
        .pm_word     (pm_rdata),
        .access_addr (ptr_access),
        .next_ptr    (ptr_next),
        .sel_byte    (pm_byte)
    );

    wire logic [7:0] opnd_src = dmem[opnd_addr[$clog2(DMEM_DEPTH)-1:0]];

    tr_opnd u_opnd (
        .fopnd      (dec.fopnd),
        .acc_banked (dec.acc_banked),
        .bank_sel   (bank_select_reg_ff),
        .ext_en     (ext_en_ff),
        .index_base (index_ff),
        .src        (opnd_src),
        .daddr      (opnd_addr),
        .swapped    (swap_val)
    );

    wire logic exec_swap  = (state_ff == ST_EXEC) && dec.is_swap;
    wire logic exec_table = (state_ff == ST_EXEC) && dec.is_table_read;
    wire logic pm_done    = (state_ff == ST_PMRD) && pm_ack;
    wire logic swap_to_f  = exec_swap && dec.dest_f;
    wire logic swap_to_w  = exec_swap && !dec.dest_f;

    // ****************************************************
    // next-state logic
    // ****************************************************
    tr_state_t nxt_state;
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (launch && !new_bad) nxt_state = ST_EXEC;
            ST_EXEC: nxt_state = dec.is_table_read ? ST_PMRD : ST_IDLE;
            ST_PMRD: if (pm_ack) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // sticky error bits: a new event beats a clear in the same cycle
    wire logic nxt_refused = (sw_conflict) ||
                             (refused_ff && !(wr_status && pwdata[ST_REFUSE_BIT]));
    wire logic nxt_unknown = (launch && new_bad) ||
                             (unknown_ff && !(wr_status && pwdata[ST_UNKN_BIT]));

    // pointer moves only when the memory answers; pre-increment already used
    wire logic [20:0] nxt_ptr = pm_done ? ptr_next :
                                (wr_ptr && idle) ? pwdata[20:0] : table_byte_pointer_ff;
    wire logic [7:0]  nxt_wreg = swap_to_w ? swap_val :
                                 (wr_wreg && idle) ? pwdata[7:0] : wreg_ff;
    wire tr_pm_req_t  nxt_pm_req =
        exec_table ? tr_pm_req_t'{rd: 1'b1, word_addr: ptr_access[20:1]} :
        pm_done    ? tr_pm_req_t'{rd: 1'b0, word_addr: pm_req_ff.word_addr} :
                     pm_req_ff;

    // ****************************************************
    // control registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= ST_IDLE;
            refused_ff <= 1'b0;
            unknown_ff <= 1'b0;
            pm_req_ff  <= '{rd: 1'b0, word_addr: 20'h00000};
        end
        else
        begin
            state_ff   <= nxt_state;
            refused_ff <= nxt_refused;
            unknown_ff <= nxt_unknown;
            pm_req_ff  <= nxt_pm_req;
        end
    end

    // ****************************************************
    // software visible registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_en_ff             <= 1'b0;
            instr_ff              <= RST_INSTR;
            table_byte_pointer_ff <= RST_PTR;
            wreg_ff               <= RST_BYTE;
            bank_select_reg_ff    <= RST_BANK;
            index_ff              <= RST_INDEX;
            dbg_addr_ff           <= RST_INDEX;
        end
        else
        begin
            if (wr_ctrl)
                ext_en_ff <= pwdata[CTRL_EXT_BIT];
            if (launch)
                instr_ff <= pwdata[15:0];
            table_byte_pointer_ff <= nxt_ptr;
            wreg_ff               <= nxt_wreg;
            if (wr_bank && idle)
                bank_select_reg_ff <= pwdata[3:0];
            if (wr_index && idle)
                index_ff <= pwdata[11:0];
            if (wr_daddr)
                dbg_addr_ff <= pwdata[11:0];
        end
    end

    // latch takes the selected byte of the returned word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            table_latch_reg_ff <= RST_BYTE;
        else if (pm_done)
            table_latch_reg_ff <= pm_byte;
    end

    // flags belong to software; no instruction here touches them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= RST_FLAGS;
        else if (wr_flags)
            flags_ff <= pwdata[4:0];
    end

    // data memory has no reset; the swap and the debug window share one port
    wire logic [$clog2(DMEM_DEPTH)-1:0] dmem_waddr =
        swap_to_f ? opnd_addr[$clog2(DMEM_DEPTH)-1:0]
                  : dbg_addr_ff[$clog2(DMEM_DEPTH)-1:0];
    wire logic       dmem_we    = swap_to_f || (wr_ddata && idle);
    wire logic [7:0] dmem_wdata = swap_to_f ? swap_val : pwdata[7:0];

    always_ff @(posedge pclk)
    begin
        if (dmem_we)
            dmem[dmem_waddr] <= dmem_wdata;
    end

    // ****************************************************
    // read mux and outputs
    // ****************************************************
    wire logic [7:0] dbg_rd = dmem[dbg_addr_ff[$clog2(DMEM_DEPTH)-1:0]];

    always_comb
    begin
        prdata = 32'h00000000;
        if (rd_acc && mapped)
        begin
            unique case (reg_off)
                ADDR_CTRL:   prdata = {31'h00000000, ext_en_ff};
                ADDR_INSTR:  prdata = {16'h0000, instr_ff};
                ADDR_PTR:    prdata = {11'h000, table_byte_pointer_ff};
                ADDR_LATCH:  prdata = {24'h000000, table_latch_reg_ff};
                ADDR_WREG:   prdata = {24'h000000, wreg_ff};
                ADDR_BANK:   prdata = {28'h0000000, bank_select_reg_ff};
                ADDR_STATUS: prdata = {29'h00000000, unknown_ff, refused_ff, !idle};
                ADDR_FLAGS:  prdata = {27'h0000000, flags_ff};
                ADDR_INDEX:  prdata = {20'h00000, index_ff};
                ADDR_DADDR:  prdata = {20'h00000, dbg_addr_ff};
                ADDR_DDATA:  prdata = {24'h000000, dbg_rd};
                default:     prdata = 32'h00000000;
            endcase
        end
    end

    // zero wait states; unmapped or misaligned addresses answer with an error
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && !mapped;
    assign pm_rd        = pm_req_ff.rd;
    assign pm_word_addr = pm_req_ff.word_addr;
    assign busy         = !idle;

endmodule : tr_core

// ### tr_pm_model.sv
// program memory read port model for the table-read block
// assumes a held pm_rd request answered by a one-cycle pm_ack
`timescale 1ns/1ps
module tr_pm_model
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // word read port
    input  wire logic        pm_rd,
    input  wire logic [19:0] pm_word_addr,
    output logic [15:0]      pm_rdata,
    output logic             pm_ack
);
    // **********************************************************
    // memory contents and answer timing
    // **********************************************************
    logic [1:0]  cnt_ff;
    logic [15:0] word_ff;
    logic        ack_ff;

    // contents derived from the word address, so no array is needed
    function automatic logic [15:0] tr_pm_word(input logic [19:0] a);
        return {~a[7:0], a[7:0] ^ a[15:8]};
    endfunction : tr_pm_word

    // random wait of 0..2 extra cycles; data toggles when not acked
    // so a late sample never sees a stale word
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_ff  <= 1'b0;
            cnt_ff  <= 2'h0;
            word_ff <= 16'h0000;
        end
        else if (ack_ff)
        begin
            ack_ff  <= 1'b0;
            word_ff <= ~word_ff;
            cnt_ff  <= 2'($urandom_range(2, 0));
        end
        else if (pm_rd && cnt_ff == 2'h0)
        begin
            ack_ff  <= 1'b1;
            word_ff <= tr_pm_word(pm_word_addr);
        end
        else
        begin
            cnt_ff  <= (cnt_ff != 2'h0) ? cnt_ff - 2'h1 : cnt_ff;
            word_ff <= ~word_ff;
        end
    end

    assign pm_ack   = ack_ff;
    assign pm_rdata = word_ff;
endmodule : tr_pm_model

// ### tr_core_asserts.sv
// port checker for tr_core
// assumes the single pclk domain and the asynchronous presetn
`timescale 1ns/1ps
module tr_core_asserts
    import tr_pkg::*;
#(
    parameter int DMEM_DEPTH = 4096
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pm_rd,
    input wire logic [19:0] pm_word_addr,
    input wire logic [15:0] pm_rdata,
    input wire logic        pm_ack,
    input wire logic        busy
);
    // **********************************************************
    // decode of launch writes
    // **********************************************************
    logic instr_wr;
    logic swap_op;
    logic tbl_op;
    assign instr_wr = psel && penable && pwrite && paddr == {24'h0, ADDR_INSTR} && !busy;
    assign swap_op  = pwdata[15:10] == SWAP_PATTERN;
    assign tbl_op   = pwdata[15:2] == TABLE_READ_PATTERN;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (psel && penable && paddr > 32'h28 |-> pslverr && prdata == 0)
        else $error("unmapped access not flagged");
    idle_rdata_a: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    status_busy_a: assert property (psel && penable && !pwrite && paddr == {24'h0, ADDR_STATUS}
        |-> prdata[0] == busy) else $error("status busy mismatch");
    swap_launch_a: assert property (instr_wr && swap_op |=> busy ##1 !busy && !pm_rd)
        else $error("swap timing wrong");
    table_launch_a: assert property (instr_wr && tbl_op |=> busy && !pm_rd ##1 pm_rd)
        else $error("table read not launched");
    bad_op_a: assert property (instr_wr && !swap_op && !tbl_op |=> !busy)
        else $error("unknown opcode executed");
    rd_hold_a: assert property (pm_rd && !pm_ack |=> pm_rd && $stable(pm_word_addr))
        else $error("read request dropped");
    rd_end_a: assert property (pm_rd && pm_ack |=> !pm_rd ##[0:1] !busy)
        else $error("read not closed");
    rd_busy_a: assert property (pm_rd |-> busy)
        else $error("read while idle");

    cover property (instr_wr && swap_op);
    cover property (instr_wr && tbl_op && pwdata[1:0] == 2'b11);
    cover property (pm_rd && pm_ack);
    cover property (pslverr);
endmodule : tr_core_asserts

bind tr_core tr_core_asserts #(.DMEM_DEPTH(DMEM_DEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_rd(pm_rd),
    .pm_word_addr(pm_word_addr), .pm_rdata(pm_rdata), .pm_ack(pm_ack), .busy(busy));

// ### tb_table_read_and_nibble_swap.sv
// self-checking bench for tr_core with a program memory model
// assumes zero-wait apb and status polling for completion
`timescale 1ns/1ps
module tb_table_read_and_nibble_swap
    import tr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic        pm_rd, pm_ack, busy, erv;
    logic [19:0] pm_word_addr;
    logic [15:0] pm_rdata, w;
    int          mismatches, checks;
    logic [7:0]  regs[9] = '{ADDR_CTRL, ADDR_INSTR, ADDR_PTR, ADDR_LATCH, ADDR_WREG,
                             ADDR_BANK, ADDR_FLAGS, ADDR_INDEX, ADDR_STATUS};
    logic [20:0] p, a21;
    logic [7:0]  f, v, w0, fl;
    logic [3:0]  bk;
    logic [11:0] ix, ad;
    logic [1:0]  md;
    logic        d, ac, ex;

    tr_core #(.DMEM_DEPTH(4096)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pm_rd(pm_rd), .pm_word_addr(pm_word_addr),
        .pm_rdata(pm_rdata), .pm_ack(pm_ack), .busy(busy));
    tr_pm_model u_pm (.pclk(pclk), .presetn(presetn), .pm_rd(pm_rd),
        .pm_word_addr(pm_word_addr), .pm_rdata(pm_rdata), .pm_ack(pm_ack));

    always #20 pclk = ~pclk;

    // **********************************************************
    // bus tasks and comparisons
    // **********************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad8, input logic [31:0] dat);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {24'h0, ad8}; pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin mismatches++; results(); end
    endtask : apb

    // completion is polled through the status busy bit, with a bound
    task automatic wait_idle();
        int n;
        n = 0;
        do begin apb(1'b0, ADDR_STATUS, 32'h0); n++; end while (rdv[0] !== 1'b0 && n < 40);
        if (n >= 40) begin mismatches++; results(); end
    endtask : wait_idle

    function automatic logic [15:0] exp_word(input logic [19:0] wa);
        return {~wa[7:0], wa[7:0] ^ wa[15:8]};
    endfunction : exp_word

    // **********************************************************
    // main sequence
    // **********************************************************
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        mismatches = 0; checks = 0;
        void'($urandom(17941));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) begin apb(1'b0, regs[i], 32'h0); chk(rdv, 32'h0); end
        apb(1'b0, 8'h40, 32'h0); chk({31'h0, erv}, 32'h1); chk(rdv, 32'h0);
        // table write opcode must be refused as unknown
        apb(1'b1, ADDR_INSTR, 32'h000c); apb(1'b0, ADDR_STATUS, 0); chk(rdv[2], 1);
        apb(1'b1, ADDR_STATUS, 32'h6); apb(1'b0, ADDR_STATUS, 0); chk(rdv, 0);
        fl = 8'($urandom()) & 8'h1f;
        apb(1'b1, ADDR_FLAGS, {24'h0, fl});
        // every pointer mode, with wrap at both ends of the 2 MB space
        for (int i = 0; i < 16; i++)
        begin
            md = i[1:0];
            p = (i == 2) ? 21'h0 : (i == 3 || i == 7) ? 21'h1fffff : 21'($urandom());
            apb(1'b1, ADDR_PTR, {11'h0, p});
            apb(1'b1, ADDR_INSTR, {28'h0, 2'b10, md});
            wait_idle();
            a21 = (md == PTR_PRE_INC) ? p + 21'h1 : p;
            w = exp_word(a21[20:1]);
            apb(1'b0, ADDR_LATCH, 0);
            chk(rdv, {24'h0, a21[0] ? w[15:8] : w[7:0]});
            p = (md == PTR_KEEP) ? p : (md == PTR_POST_DEC) ? p - 21'h1 : p + 21'h1;
            apb(1'b0, ADDR_PTR, 0); chk(rdv, {11'h0, p});
        end
        // pointer write during a table read is refused
        apb(1'b1, ADDR_PTR, 32'h123); apb(1'b1, ADDR_INSTR, 32'h0009);
        apb(1'b1, ADDR_PTR, 32'h777); wait_idle();
        apb(1'b0, ADDR_PTR, 0); chk(rdv, 32'h124);
        apb(1'b0, ADDR_STATUS, 0); chk(rdv[1], 1);
        // swaps across both destinations and all addressing modes
        for (int i = 0; i < 24; i++)
        begin
            f = (i == 0) ? 8'h5f : (i == 1) ? 8'h60 : 8'($urandom());
            d = 1'($urandom()); ac = (i < 6) ? 1'b0 : 1'($urandom()); ex = 1'($urandom());
            bk = 4'($urandom()); ix = 12'($urandom()); v = 8'($urandom()); w0 = 8'($urandom());
            apb(1'b1, ADDR_CTRL, {31'h0, ex}); apb(1'b1, ADDR_BANK, {28'h0, bk});
            apb(1'b1, ADDR_INDEX, {20'h0, ix}); apb(1'b1, ADDR_WREG, {24'h0, w0});
            ad = ac ? {bk, f} : (ex && f <= 8'h5f) ? ix + {4'h0, f} : {f > 8'h5f ? 4'hf : 4'h0, f};
            apb(1'b1, ADDR_DADDR, {20'h0, ad}); apb(1'b1, ADDR_DDATA, {24'h0, v});
            apb(1'b1, ADDR_INSTR, {16'h0, SWAP_PATTERN, d, ac, f});
            wait_idle();
            apb(1'b0, ADDR_DDATA, 0); chk(rdv, {24'h0, d ? {v[3:0], v[7:4]} : v});
            apb(1'b0, ADDR_WREG, 0); chk(rdv, {24'h0, d ? w0 : {v[3:0], v[7:4]}});
        end
        apb(1'b0, ADDR_FLAGS, 0); chk(rdv, {24'h0, fl});
        results();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        results();
    end
endmodule : tb_table_read_and_nibble_swap
